// ===== src/link_mon.sv
// ----------------------------------------------------------------------------
// serial link error and status monitor, receiver side
// ----------------------------------------------------------------------------
// assumes one clock cycle per received octet on every lane, error inputs as
// one-cycle pulses, and an apb master on the register side
module link_mon #(
   parameter int LANES = 4,
   parameter int OCTETS_PER_FRAME = 2
) (
   input wire logic I_CLK, // 25 MHz clock
   input wire logic I_SYS_RST, // synchronous reset, high
   input wire logic I_PSEL, // apb select
   input wire logic I_PENABLE, // apb enable
   input wire logic I_PWRITE, // apb direction
   input wire logic [13:0] I_PADDR, // apb byte address
   input wire logic [31:0] I_PWDATA, // apb write data
   output logic [31:0] O_PRDATA, // apb read data
   output logic O_PREADY, // apb ready
   output logic O_PSLVERR, // apb error, unmapped address
   input wire logic [LANES-1:0] I_DISP_ERR, // bad disparity pulse per lane
   input wire logic [LANES-1:0] I_NIT_ERR, // not-in-table pulse per lane
   input wire logic [LANES-1:0] I_UCC_ERR, // unexpected control pulse per lane
   input wire logic [LANES-1:0] I_CGS_DONE, // code group sync reached
   input wire logic [LANES-1:0] I_FRAME_SYNC_DONE, // frame sync reached
   input wire logic [LANES-1:0] I_ALIGN_DONE, // lane alignment passed
   input wire logic [LANES*8-1:0] I_RX_CHECKSUM, // received checksum per lane
   input wire logic [LANES*5-1:0] I_RX_LANE_ID, // received lane id per lane
   input wire logic [link_mon_pkg::CFG_BYTES*8-1:0] I_RX_CFG, // received link settings
   output logic O_SYNC_REQ_N, // sync request output, low requests
   output logic O_IRQ // combined interrupt, high
);
   localparam int SYNC_LEN = link_mon_pkg::SYNC_FRAMES * OCTETS_PER_FRAME
      + link_mon_pkg::SYNC_EXTRA_OCTETS;

   // lane select is three bits and bit 7 of each flag register is a clear
   if (LANES < 1 || LANES > 7 || OCTETS_PER_FRAME < 1 || SYNC_LEN > 65535)
   begin : g_bad_param
      $error("link_mon: unsupported LANES or OCTETS_PER_FRAME");
   end

   typedef struct packed {
      logic [LANES-1:0][link_mon_pkg::ERR_TYPES-1:0][7:0] cnt;
      logic [LANES-1:0][link_mon_pkg::ERR_TYPES-1:0] cnt_dis;
      logic [LANES-1:0][link_mon_pkg::ERR_TYPES-1:0] over_irq;
      logic [LANES-1:0][2:0] disp_seen;
      logic [3:0][LANES-1:0] flags;
      logic [3:0] fail_irq;
      logic mismatch;
      logic [7:0] err_sel;
      logic [7:0] thresh;
      logic [7:0] sync_mask;
      logic [7:0] link_ctrl;
      logic [7:0] irq_en;
      logic [7:0] chk_mode;
      logic [link_mon_pkg::CFG_BYTES-1:0][7:0] local_cfg;
      logic [15:0] sync_cnt;
      logic sync_n;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

   state_t s;
   state_t next_s;
   logic [link_mon_pkg::CFG_BYTES-1:0][7:0] rx_cfg;
   logic [LANES-1:0][link_mon_pkg::ERR_TYPES-1:0] err_in;
   logic [LANES-1:0][7:0] calc_chk;
   logic [LANES-1:0] chk_match;
   logic disp_trig;
   logic thr_trig;
   logic reinit;
   logic [2:0] type_stat;

   assign rx_cfg = I_RX_CFG;

   // ----------------------------------------------------------------------------
   // checksum per lane
   // ----------------------------------------------------------------------------
   function automatic logic [7:0] chk_calc(
      input logic [link_mon_pkg::CFG_BYTES-1:0][7:0] c,
      input logic [4:0] lid,
      input logic packed_mode
   );
      logic [7:0] sum;
      sum = {3'h0, lid};
      if (packed_mode)
      begin
         for (int i = 0; i < link_mon_pkg::PACKED_BYTES; i++)
            sum = sum + c[i];
      end
      else
      begin
         // did, bid, scr, l, f, k, m, n, subclass, np, version, s, hd
         sum = sum + c[0] + {4'h0, c[1][3:0]} + {7'h00, c[3][7]}
            + {3'h0, c[3][4:0]} + c[4] + {3'h0, c[5][4:0]} + c[6]
            + {3'h0, c[7][4:0]} + {5'h00, c[8][7:5]} + {3'h0, c[8][4:0]}
            + {5'h00, c[9][7:5]} + {3'h0, c[9][4:0]} + {7'h00, c[10][7]};
      end
      return sum;
   endfunction

   for (genvar l = 0; l < LANES; l++)
   begin : g_lane
      assign err_in[l] = {I_UCC_ERR[l], I_NIT_ERR[l], I_DISP_ERR[l]};
      // mode bit picks field or packed sum
      assign calc_chk[l] = chk_calc(rx_cfg, I_RX_LANE_ID[l*5 +: 5],
         s.chk_mode[link_mon_pkg::BIT_CHKSUM_MODE]);
      assign chk_match[l] = calc_chk[l] == I_RX_CHECKSUM[l*8 +: 8];
   end

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      logic req;
      logic acc;
      logic hit;
      logic [11:0] idx;
      logic [7:0] wd;
      logic [2:0] wl;
      logic [31:0] rd;
      logic wrap;
      logic [7:0] inc;
      logic [3:0][LANES-1:0] cur;
      logic [3:0] fail_ev;
      logic [3:0] flag_clr;
      req = I_PSEL && I_PENABLE;
      acc = req && s.pready;
      idx = I_PADDR[13:2];
      wd = I_PWDATA[7:0];
      wl = I_PWDATA[2:0];
      rd = 32'h0000_0000;
      hit = I_PADDR[1:0] == 2'h0;
      disp_trig = 1'b0;
      thr_trig = 1'b0;
      wrap = 1'b0;
      inc = 8'h00;
      next_s = s;

      // ---------------------------------------------------------------------
      // lane error counters
      // ---------------------------------------------------------------------
      for (int l = 0; l < LANES; l++)
      begin
         // fourth bad disparity character since last reinit
         if (I_DISP_ERR[l])
         begin
            if (s.disp_seen[l] == link_mon_pkg::DISP_REINIT_COUNT - 3'h1)
               disp_trig = 1'b1;
            next_s.disp_seen[l] = s.disp_seen[l] + 3'h1;
         end
         for (int t = 0; t < link_mon_pkg::ERR_TYPES; t++)
         begin
            // unmasked types count on past threshold and wrap
            wrap = s.link_ctrl[link_mon_pkg::BIT_THRESHOLD_MASK_EN] && s.sync_mask[7-t];
            inc = s.cnt[l][t] + 8'h01;
            if (err_in[l][t] && !s.cnt_dis[l][t] && (wrap || s.cnt[l][t] < s.thresh))
            begin
               next_s.cnt[l][t] = inc;
               // one threshold for all types and lanes
               if (inc == s.thresh)
               begin
                  next_s.over_irq[l][t] = 1'b1;
                  if (wrap)
                     thr_trig = 1'b1;
               end
            end
         end
      end
      reinit = disp_trig || thr_trig;

      // ---------------------------------------------------------------------
      // link establishment flags and failure events
      // ---------------------------------------------------------------------
      // per-lane stage flags
      cur[0] = I_CGS_DONE;
      cur[1] = I_FRAME_SYNC_DONE;
      // good checksum once alignment data is in
      cur[2] = I_ALIGN_DONE & chk_match;
      cur[3] = I_ALIGN_DONE;
      next_s.flags = cur;
      // loss of a stage is a failure; checksum fails at alignment with mismatch
      fail_ev[0] = |(s.flags[0] & ~cur[0]);
      fail_ev[1] = |(s.flags[1] & ~cur[1]);
      fail_ev[2] = |(I_ALIGN_DONE & ~s.flags[3] & ~chk_match);
      fail_ev[3] = |(s.flags[3] & ~cur[3]);

      // ---------------------------------------------------------------------
      // register bus
      // ---------------------------------------------------------------------
      case (idx)
         link_mon_pkg::IDX_ERR_COUNT:
            if (s.err_sel[6:4] < 3'(LANES) && s.err_sel[1:0] < 2'h3)
               rd[7:0] = s.cnt[s.err_sel[6:4]][s.err_sel[1:0]];
         link_mon_pkg::IDX_ERR_DISP, link_mon_pkg::IDX_ERR_NIT, link_mon_pkg::IDX_ERR_UCC:
            // lane bit high while its count is at or over threshold
            for (int l = 0; l < LANES; l++)
               rd[l] = s.cnt[l][idx[1:0] - 2'h1] >= s.thresh;
         link_mon_pkg::IDX_CGS_FLAGS, link_mon_pkg::IDX_FSYNC_FLAGS,
         link_mon_pkg::IDX_CHKSUM_FLAGS, link_mon_pkg::IDX_ALIGN_FLAGS:
            rd[LANES-1:0] = s.flags[idx[1:0]];
         link_mon_pkg::IDX_LINK_CTRL: rd[7:0] = s.link_ctrl;
         link_mon_pkg::IDX_IRQ_EN_STAT:
            rd[7:0] = {s.irq_en[7:5] & type_stat, 1'b0, s.irq_en[3:0] & s.fail_irq};
         link_mon_pkg::IDX_SYNC_MASK:
            rd[7:0] = {s.sync_mask[7:5], s.mismatch, s.sync_mask[3], 3'h0};
         link_mon_pkg::IDX_THRESHOLD: rd[7:0] = s.thresh;
         link_mon_pkg::IDX_CHKSUM_MODE: rd[7:0] = s.chk_mode;
         default:
            if (idx >= link_mon_pkg::IDX_LOCAL_CFG
               && idx < link_mon_pkg::IDX_LOCAL_CFG + 12'(link_mon_pkg::CFG_BYTES))
               rd[7:0] = s.local_cfg[4'(idx - link_mon_pkg::IDX_LOCAL_CFG)];
            else
               hit = 1'b0;
      endcase

      flag_clr = 4'h0;
      if (acc && I_PWRITE && hit)
      begin
         case (idx)
            link_mon_pkg::IDX_ERR_COUNT: next_s.err_sel = wd;
            link_mon_pkg::IDX_ERR_DISP, link_mon_pkg::IDX_ERR_NIT, link_mon_pkg::IDX_ERR_UCC:
               // irq clear, count disable and count clear for one lane
               if (wl < 3'(LANES))
               begin
                  if (wd[link_mon_pkg::BIT_LANE_IRQ_CLEAR])
                     next_s.over_irq[wl][idx[1:0]-2'h1] = 1'b0;
                  next_s.cnt_dis[wl][idx[1:0]-2'h1] = wd[link_mon_pkg::BIT_LANE_COUNT_DISABLE];
                  if (wd[link_mon_pkg::BIT_LANE_COUNT_CLEAR])
                     next_s.cnt[wl][idx[1:0]-2'h1] = 8'h00;
               end
            link_mon_pkg::IDX_CGS_FLAGS, link_mon_pkg::IDX_FSYNC_FLAGS,
            link_mon_pkg::IDX_CHKSUM_FLAGS, link_mon_pkg::IDX_ALIGN_FLAGS:
               // bit seven clears that category's failure irq
               flag_clr[idx[1:0]] = wd[link_mon_pkg::BIT_FLAG_IRQ_CLEAR];
            link_mon_pkg::IDX_LINK_CTRL: next_s.link_ctrl = wd;
            // enables live in the same register as status
            link_mon_pkg::IDX_IRQ_EN_STAT: next_s.irq_en = {wd[7:5], 1'b0, wd[3:0]};
            link_mon_pkg::IDX_SYNC_MASK:
            begin
               // sync enables and mismatch irq enable
               next_s.sync_mask = {wd[7:5], 1'b0, wd[3], 3'h0};
               if (wd[link_mon_pkg::BIT_MISMATCH_STAT])
                  next_s.mismatch = 1'b0;
            end
            link_mon_pkg::IDX_THRESHOLD: next_s.thresh = wd;
            link_mon_pkg::IDX_CHKSUM_MODE: next_s.chk_mode = wd;
            default: next_s.local_cfg[4'(idx - link_mon_pkg::IDX_LOCAL_CFG)] = wd;
         endcase
      end

      // failure set wins over a clear in the same cycle
      next_s.fail_irq = (s.fail_irq & ~flag_clr) | fail_ev;
      // settings checked when alignment data arrives; set wins
      if (|(I_ALIGN_DONE & ~s.flags[3]) && s.local_cfg != rx_cfg)
         next_s.mismatch = 1'b1;
      // over-threshold events landing with a clear still win
      for (int l = 0; l < LANES; l++)
         for (int t = 0; t < link_mon_pkg::ERR_TYPES; t++)
            if (err_in[l][t] && !s.cnt_dis[l][t] && s.cnt[l][t] + 8'h01 == s.thresh
               && (s.cnt[l][t] < s.thresh
               || (s.link_ctrl[link_mon_pkg::BIT_THRESHOLD_MASK_EN] && s.sync_mask[7-t])))
               next_s.over_irq[l][t] = 1'b1;

      // ---------------------------------------------------------------------
      // reinitialisation and sync request
      // ---------------------------------------------------------------------
      if (reinit)
      begin
         // all counts cleared; irq state kept as is
         next_s.cnt = '0;
         next_s.disp_seen = '0;
      end
      // one fixed-length request, not restarted while running
      if (reinit && s.sync_cnt == 16'h0000)
         next_s.sync_cnt = 16'(SYNC_LEN);
      else if (s.sync_cnt != 16'h0000)
         next_s.sync_cnt = s.sync_cnt - 16'h0001;
      next_s.sync_n = next_s.sync_cnt == 16'h0000;

      // combined output from enabled sticky bits
      next_s.irq = |(s.irq_en[7:5] & type_stat) || |(s.irq_en[3:0] & s.fail_irq)
         || (s.mismatch && s.sync_mask[link_mon_pkg::BIT_MISMATCH_EN]);

      // one wait state: ready is raised a cycle into the access phase
      next_s.pready = req && !s.pready;
      if (req && !s.pready)
      begin
         next_s.prdata = rd;
         next_s.pslverr = !hit;
      end
      else if (!req)
         next_s.pslverr = 1'b0;
   end

   for (genvar t = 0; t < link_mon_pkg::ERR_TYPES; t++)
   begin : g_type
      logic [LANES-1:0] lanes_irq;
      for (genvar l = 0; l < LANES; l++)
      begin : g_l
         assign lanes_irq[l] = s.over_irq[l][t];
      end
      assign type_stat[2-t] = |lanes_irq;
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         s <= '0;
         s.thresh <= link_mon_pkg::RST_THRESHOLD;
         s.sync_mask <= link_mon_pkg::RST_SYNC_MASK;
         s.link_ctrl <= link_mon_pkg::RST_LINK_CTRL;
         s.irq_en <= link_mon_pkg::RST_IRQ_EN;
         s.chk_mode <= link_mon_pkg::RST_CHKSUM_MODE;
         s.sync_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign O_PRDATA = s.prdata;
   assign O_PREADY = s.pready;
   assign O_PSLVERR = s.pslverr;
   assign O_SYNC_REQ_N = s.sync_n;
   assign O_IRQ = s.irq;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   logic [15:0] low_run;
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST || s.sync_n)
         low_run <= 16'h0000;
      else
         low_run <= low_run + 16'h0001;
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);

   sequence seq_apb_first;
      I_PSEL && I_PENABLE && !O_PREADY;
   endsequence
   sequence seq_apb_done;
      O_PREADY ##1 !O_PREADY;
   endsequence

   chk_sync_length: assert property ($rose(O_SYNC_REQ_N) |-> low_run == 16'(SYNC_LEN))
      else $error("sync request length wrong");
   chk_disp_reinit: assert property (disp_trig && s.sync_cnt == 16'h0000 |=> !O_SYNC_REQ_N)
      else $error("disparity reinit missing");
   chk_thr_sync: assert property (thr_trig && O_SYNC_REQ_N |=> !O_SYNC_REQ_N ##1 !O_SYNC_REQ_N)
      else $error("threshold sync request missing");
   chk_cnt_cleared: assert property (reinit |=> s.cnt == '0)
      else $error("counters not cleared on reinit");
   chk_irq_kept: assert property (reinit && |s.over_irq |=> |s.over_irq)
      else $error("reinit cleared irq status");
   chk_irq_output: assert property (|(s.irq_en[3:0] & s.fail_irq) |=> O_IRQ)
      else $error("combined irq not raised");
   chk_mismatch_set: assert property (|(I_ALIGN_DONE & ~s.flags[3]) && s.local_cfg != rx_cfg
      |=> s.mismatch)
      else $error("config mismatch not flagged");
   chk_fail_clear: assert property ($fell(s.fail_irq[0]) |-> $past(I_PWRITE && O_PREADY))
      else $error("cgs irq cleared without write");
   chk_apb_answer: assert property (seq_apb_first |=> seq_apb_done)
      else $error("apb answer timing wrong");

endmodule // link_mon

// ===== src/link_mon_pkg.sv
// ----------------------------------------------------------------------------
// link monitor package
// ----------------------------------------------------------------------------
// register indices, field positions, reset values and timing counts for the
// serial link error and status monitor; the byte address of a register is
// four times its index on the register bus
package link_mon_pkg;
   // register indices
   localparam logic [11:0] IDX_ERR_COUNT = 12'h46B;
   localparam logic [11:0] IDX_ERR_DISP = 12'h46D;
   localparam logic [11:0] IDX_ERR_NIT = 12'h46E;
   localparam logic [11:0] IDX_ERR_UCC = 12'h46F;
   localparam logic [11:0] IDX_CGS_FLAGS = 12'h470;
   localparam logic [11:0] IDX_FSYNC_FLAGS = 12'h471;
   localparam logic [11:0] IDX_CHKSUM_FLAGS = 12'h472;
   localparam logic [11:0] IDX_ALIGN_FLAGS = 12'h473;
   localparam logic [11:0] IDX_LINK_CTRL = 12'h477;
   localparam logic [11:0] IDX_IRQ_EN_STAT = 12'h47A;
   localparam logic [11:0] IDX_SYNC_MASK = 12'h47B;
   localparam logic [11:0] IDX_THRESHOLD = 12'h47C;
   localparam logic [11:0] IDX_CHKSUM_MODE = 12'h300;
   localparam logic [11:0] IDX_LOCAL_CFG = 12'h450;
   localparam int CFG_BYTES = 14;
   localparam int PACKED_BYTES = 13;
   // field positions
   localparam int BIT_LANE_IRQ_CLEAR = 7;
   localparam int BIT_LANE_COUNT_DISABLE = 6;
   localparam int BIT_LANE_COUNT_CLEAR = 5;
   localparam int BIT_FLAG_IRQ_CLEAR = 7;
   localparam int BIT_THRESHOLD_MASK_EN = 3;
   localparam int BIT_CHKSUM_MODE = 6;
   localparam int BIT_MISMATCH_EN = 3;
   localparam int BIT_MISMATCH_STAT = 4;
   localparam int BIT_ERR_IRQ_LSB = 5;
   localparam int BIT_CNT_LANE_LSB = 4;
   // error types; the mask and irq bit of type t is bit 7 - t
   localparam int ERR_DISP = 0;
   localparam int ERR_NIT = 1;
   localparam int ERR_UCC = 2;
   localparam int ERR_TYPES = 3;
   // reset values
   localparam logic [7:0] RST_THRESHOLD = 8'hFF;
   localparam logic [7:0] RST_SYNC_MASK = 8'h08;
   localparam logic [7:0] RST_LINK_CTRL = 8'h00;
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam logic [7:0] RST_CHKSUM_MODE = 8'h00;
   // timing: sync request length and disparity reinit count
   localparam int SYNC_FRAMES = 5;
   localparam int SYNC_EXTRA_OCTETS = 9;
   localparam logic [2:0] DISP_REINIT_COUNT = 3'h4;
endpackage

// ===== verification/link_tx_model.sv
// ----------------------------------------------------------------------------
// transmitter model for the link monitor bench
// ----------------------------------------------------------------------------
// link bring-up seen at the receiver; assumes one octet per clock per lane
module link_tx_model #(
   parameter int LANES = 4
) (
   input wire logic i_clk, // bench clock
   input wire logic i_sync_req_n, // sync request from the receiver
   output logic [LANES-1:0] o_cgs, // code group sync reached
   output logic [LANES-1:0] o_fsync, // frame sync reached
   output logic [LANES-1:0] o_align, // lane alignment passed
   output logic [LANES*8-1:0] o_chk, // checksum sent per lane
   output logic [LANES*5-1:0] o_lid, // lane id sent per lane
   output logic [111:0] o_cfg // link settings sent during alignment
);
   timeunit 1ns;
   timeprecision 1ps;
   int up = 0;
   always @(posedge i_clk)
   begin
      if (i_sync_req_n !== 1'b1)
         up <= 0;
      else if (up < 40)
         up <= up + 1;
   end
   assign o_cgs = {LANES{up >= 4}};
   assign o_fsync = {LANES{up >= 8}};
   assign o_align = {LANES{up >= 12}};
   // settings byte k is k+1; checksum uses the packed sum plus lane id
   always_comb
   begin
      for (int k = 0; k < 14; k++)
         o_cfg[8*k +: 8] = 8'(k + 1);
      for (int l = 0; l < LANES; l++)
      begin
         o_lid[5*l +: 5] = 5'(l);
         o_chk[8*l +: 8] = 8'(91 + l);
      end
   end
endmodule // link_tx_model

// ===== verification/tb_serial_link_error_irq_monitor.sv
// ----------------------------------------------------------------------------
// self-checking bench for the link monitor
// ----------------------------------------------------------------------------
// apb master tasks, error pulse driver and the transmitter model around link_mon
module tb_serial_link_error_irq_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPF = 2;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, irq, sync_n, pready, pslverr;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] disp = 4'h0, nit = 4'h0, ucc = 4'h0, cgs, fs, al;
   logic [31:0] chk_v;
   logic [19:0] lid;
   logic [111:0] cfg;
   logic [7:0] seed = 8'h51;
   int err_total = 0, checks_done = 0;
   logic perr;
   // reference model of the lane error counters, kept from the rules
   int mcnt[4][3];
   int mdisp[4];
   int mthr = link_mon_pkg::RST_THRESHOLD;
   bit mdis[4][3];
   bit mctl = 1'b0;
   bit [2:0] mmsk = 3'h0;
   link_mon #(.LANES(4), .OCTETS_PER_FRAME(OPF)) dut (.I_CLK(clk), .I_SYS_RST(rst),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DISP_ERR(disp),
      .I_NIT_ERR(nit), .I_UCC_ERR(ucc), .I_CGS_DONE(cgs), .I_FRAME_SYNC_DONE(fs),
      .I_ALIGN_DONE(al), .I_RX_CHECKSUM(chk_v), .I_RX_LANE_ID(lid), .I_RX_CFG(cfg),
      .O_SYNC_REQ_N(sync_n), .O_IRQ(irq));
   link_tx_model #(.LANES(4)) tx (.i_clk(clk), .i_sync_req_n(sync_n), .o_cgs(cgs),
      .o_fsync(fs), .o_align(al), .o_chk(chk_v), .o_lid(lid), .o_cfg(cfg));
   initial
   begin
      forever #20 clk = ~clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
      int t;
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1;
      // only the watchdog ends a wait for the answer
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      perr = pslverr;
      psel <= 0;
      pen <= 0;
      if (w)
      begin
         if (idx == link_mon_pkg::IDX_THRESHOLD) mthr = d;
         if (idx == link_mon_pkg::IDX_LINK_CTRL) mctl = d[3];
         if (idx == link_mon_pkg::IDX_SYNC_MASK) mmsk = d[7:5];
         if (idx >= link_mon_pkg::IDX_ERR_DISP && idx <= link_mon_pkg::IDX_ERR_UCC
            && d[2:0] < 3'h4)
         begin
            t = idx - link_mon_pkg::IDX_ERR_DISP;
            mdis[d[2:0]][t] = d[6];
            if (d[5]) mcnt[d[2:0]][t] = 0;
         end
      end
   endtask
   task automatic rd(input logic [11:0] idx, input logic [7:0] m, input logic [7:0] e);
      apb(0, idx, 8'h00);
      chk(r & {24'h0, m}, {24'h0, e});
   endtask
   task automatic cnt(input int l, input int t, input logic [7:0] e);
      apb(1, link_mon_pkg::IDX_ERR_COUNT, 8'((l << 4) | t));
      rd(link_mon_pkg::IDX_ERR_COUNT, 8'hFF, e);
      chk(r, 32'(mcnt[l][t]));
   endtask
   task automatic pulse(input int t, input int l, input int n);
      bit wr;
      bit hit;
      repeat (n)
      begin
         @(posedge clk);
         if (t == 0) disp <= 4'(1 << l);
         if (t == 1) nit <= 4'(1 << l);
         if (t == 2) ucc <= 4'(1 << l);
         @(posedge clk);
         disp <= 0;
         nit <= 0;
         ucc <= 0;
         // the pulse was sampled at this edge: step the model
         wr = mctl && mmsk[2-t];
         hit = 1'b0;
         if (!mdis[l][t] && (wr || mcnt[l][t] < mthr))
         begin
            mcnt[l][t] = (mcnt[l][t] + 1) % 256;
            hit = wr && mcnt[l][t] == mthr;
         end
         if (t == 0)
            mdisp[l]++;
         if (hit || mdisp[l] == 4)
         begin
            mcnt = '{default: 0};
            mdisp = '{default: 0};
         end
      end
   endtask
   task automatic synclen();
      int n, w;
      w = 0;
      n = 0;
      while (sync_n !== 1'b0 && w < 10)
      begin
         @(posedge clk);
         w++;
      end
      while (sync_n === 1'b0 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk(n, 5 * OPF + 9);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 0;
      rd(link_mon_pkg::IDX_THRESHOLD, 8'hFF, 8'hFF);
      rd(link_mon_pkg::IDX_SYNC_MASK, 8'h08, 8'h08);
      apb(0, 12'h001, 8'h00);
      chk({31'h0, perr}, 1);
      seed = lfsr(seed);
      apb(1, link_mon_pkg::IDX_THRESHOLD, seed);
      rd(link_mon_pkg::IDX_THRESHOLD, 8'hFF, seed);
      for (int k = 0; k < 14; k++)
         apb(1, 12'(link_mon_pkg::IDX_LOCAL_CFG + k), 8'(k + 1));
      apb(1, link_mon_pkg::IDX_SYNC_MASK, 8'h18);
      // field sum of the sent settings differs from the sent checksum
      rd(link_mon_pkg::IDX_CHKSUM_FLAGS, 8'h0F, 8'h00);
      apb(1, link_mon_pkg::IDX_CHKSUM_MODE, 8'h40);
      for (int k = 0; k < 4; k++)
         rd(12'(link_mon_pkg::IDX_CGS_FLAGS + k), 8'h0F, 8'h0F);
      rd(link_mon_pkg::IDX_CHKSUM_FLAGS, 8'h0F, 8'h0F);
      apb(1, link_mon_pkg::IDX_THRESHOLD, 8'h02);
      apb(1, link_mon_pkg::IDX_IRQ_EN_STAT, 8'hFF);
      pulse(2, 1, 3);
      rd(link_mon_pkg::IDX_ERR_UCC, 8'h0F, 8'h02);
      cnt(1, 2, 8'h02);
      rd(link_mon_pkg::IDX_IRQ_EN_STAT, 8'hE0, 8'h20);
      chk({31'h0, irq}, 1);
      pulse(0, 2, 3);
      @(posedge clk);
      chk({31'h0, sync_n}, 1);
      pulse(0, 2, 1);
      synclen();
      cnt(1, 2, 8'h00);
      rd(link_mon_pkg::IDX_IRQ_EN_STAT, 8'hE0, 8'hA0);
      repeat (20) @(posedge clk);
      apb(0, link_mon_pkg::IDX_IRQ_EN_STAT, 8'h00);
      chk({31'h0, (r[3:0] != 4'h0)}, 1);
      rd(link_mon_pkg::IDX_SYNC_MASK, 8'h10, 8'h00);
      apb(1, link_mon_pkg::IDX_ERR_UCC, 8'hA1);
      apb(1, link_mon_pkg::IDX_ERR_DISP, 8'hA2);
      for (int k = 0; k < 4; k++)
         apb(1, 12'(link_mon_pkg::IDX_CGS_FLAGS + k), 8'h80);
      rd(link_mon_pkg::IDX_IRQ_EN_STAT, 8'hFF, 8'h00);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 0);
      apb(1, link_mon_pkg::IDX_ERR_DISP, 8'h43);
      pulse(0, 3, 2);
      cnt(3, 0, 8'h00);
      apb(1, link_mon_pkg::IDX_LINK_CTRL, 8'h08);
      apb(1, link_mon_pkg::IDX_SYNC_MASK, 8'h48);
      apb(1, link_mon_pkg::IDX_THRESHOLD, 8'h03);
      pulse(1, 0, 3);
      synclen();
      repeat (20) @(posedge clk);
      apb(1, link_mon_pkg::IDX_LOCAL_CFG, 8'h77);
      pulse(0, 0, 4);
      synclen();
      repeat (20) @(posedge clk);
      rd(link_mon_pkg::IDX_SYNC_MASK, 8'h10, 8'h10);
      results();
   end
endmodule // tb_serial_link_error_irq_monitor
